// >>> logic/iic_core.sv
// Purpose: Bus decode, input read-back and change-of-state interrupt for sixteen inputs.
// Assumes: Host strobes and address arrive asynchronously and are synchronised here.
// Notes:   Each strobe is acted on once, at its synchronised falling edge.
// How it works
// - Respond only to the eight I/O addresses starting at the base.
// - Every transfer is a single byte; no wider accesses are supported.
// - All sixteen input channels are watched for change of state.
// - A read at offset two enables change-of-state interrupts.
// - When enabled, any rising or falling input edge raises the interrupt.
// - The interrupt stays set until a write at offset one clears it.
// - A write at offset two disables change-of-state interrupts.
// - The interrupt drives one jumper-selected line among the allowed levels.
// - Address bits three to nine match the base; bits zero to two select.
module iic_core
  import iic_pkg::*;
#(
  parameter int Channels = ChannelCount
) (
  // Clock and reset
  input  wire logic                sys_clk,
  input  wire logic                reset_n,
  // Jumper settings
  input  wire logic [6:0]          baseJumper,
  input  wire logic [3:0]          irqSelect,
  // Host bus
  input  wire logic [AddrWidth-1:0] hostAddr,
  input  wire logic                ioRead_n,
  input  wire logic                ioWrite_n,
  input  wire logic                addrEnable,
  output logic      [7:0]          dataOut,
  output logic                     dataOutEn,
  // Interrupt lines
  output logic [IrqLineCount-1:0]  irqOut,
  output logic [IrqLineCount-1:0]  irqOutEn,
  // Field inputs
  input  wire logic [Channels-1:0] fieldIn
);
  logic [Channels-1:0] inSync;
  logic [AddrWidth-1:0] addrSync;
  logic [2:0]           strbSync;
  logic [AddrWidth+2:0] busPins;

  iic_sync #(.Width(Channels)) u_sync_in (
    .sys_clk (sys_clk),
    .reset_n (reset_n),
    .asyncIn (fieldIn),
    .syncOut (inSync)
  );

  assign busPins = {hostAddr, ioRead_n, ioWrite_n, addrEnable};

  iic_sync #(.Width(AddrWidth + 3)) u_sync_bus (
    .sys_clk (sys_clk),
    .reset_n (reset_n),
    .asyncIn (busPins),
    .syncOut ({addrSync, strbSync})
  );

  // Strobe decode and edge history.
  logic                    rdPrev_q;
  logic                    rdPrev_d;
  logic                    wrPrev_q;
  logic                    wrPrev_d;
  logic                    selected;
  logic                    rdLevel;
  logic                    wrLevel;
  logic                    rdStart;
  logic                    wrStart;
  logic [2:0]              regSel;

  always_comb begin
    rdLevel  = ~strbSync[2] & ~strbSync[0];
    wrLevel  = ~strbSync[1] & ~strbSync[0];
    regSel   = addrSync[BaseLsb-1:0];
    selected = (addrSync[AddrWidth-1:BaseLsb] == baseJumper);
    rdStart  = rdLevel & ~rdPrev_q & selected;
    wrStart  = wrLevel & ~wrPrev_q & selected;
    rdPrev_d = rdLevel;
    wrPrev_d = wrLevel;
  end

  // The synchroniser resets to zero, which reads as both strobes low with the
  // address gate open. Holding the history high across reset keeps that from
  // posing as a fresh strobe edge in the first cycles after release.
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rdPrev_q <= 1'b1;
      wrPrev_q <= 1'b1;
    end else begin
      rdPrev_q <= rdPrev_d;
      wrPrev_q <= wrPrev_d;
    end
  end

  // Change-of-state watch, one comparator per channel.
  logic [Channels-1:0]     last_q;
  logic [Channels-1:0]     last_d;
  logic [Channels-1:0]     chgBit;
  logic                    changed;

  for (genvar ch = 0; ch < Channels; ch++) begin : g_watch
    assign chgBit[ch] = inSync[ch] ^ last_q[ch];
  end

  always_comb begin
    last_d  = inSync;
    changed = |chgBit;
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      last_q <= '0;
    end else begin
      last_q <= last_d;
    end
  end

  // Enable and pending flags.
  logic                    enable_q;
  logic                    enable_d;
  logic                    pending_q;
  logic                    pending_d;

  always_comb begin
    enable_d = enable_q;
    if (rdStart && regSel == OffEnable) begin
      enable_d = 1'b1;
    end else if (wrStart && regSel == OffEnable) begin
      enable_d = 1'b0;
    end
    // A change seen in the clearing cycle wins so that no edge is lost.
    pending_d = pending_q;
    if (enable_q && changed) begin
      pending_d = 1'b1;
    end else if (wrStart && regSel == OffClear) begin
      pending_d = 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      enable_q  <= EnableReset;
      pending_q <= PendingReset;
    end else begin
      enable_q  <= enable_d;
      pending_q <= pending_d;
    end
  end

  // Read data path.
  logic [7:0]              data_q;
  logic [7:0]              data_d;
  logic                    drive_q;
  logic                    drive_d;

  always_comb begin
    // Drive starts only on a seen strobe edge, so the reset state of the
    // synchroniser can never turn the data bus around on its own.
    drive_d = rdLevel & selected & (rdStart | drive_q);
    data_d  = 8'h00;
    if (regSel == OffInputLow) begin
      data_d = inSync[7:0];
    end else if (regSel == OffInputHigh) begin
      data_d = inSync[Channels-1:8];
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      data_q  <= 8'h00;
      drive_q <= 1'b0;
    end else begin
      data_q  <= data_d;
      drive_q <= drive_d;
    end
  end

  // Interrupt line steering, one slot per bus line.
  logic [IrqLineCount-1:0] irq_q;
  logic [IrqLineCount-1:0] irq_d;
  logic [IrqLineCount-1:0] irqEn_q;
  logic [IrqLineCount-1:0] irqEn_d;

  for (genvar ln = 0; ln < IrqLineCount; ln++) begin : g_line
    assign irqEn_d[ln] = (irqSelect == 4'(ln));
    assign irq_d[ln]   = (irqSelect == 4'(ln)) & pending_q;
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      irq_q   <= '0;
      irqEn_q <= '0;
    end else begin
      irq_q   <= irq_d;
      irqEn_q <= irqEn_d;
    end
  end

  assign dataOut   = data_q;
  assign dataOutEn = drive_q;
  assign irqOut    = irq_q;
  assign irqOutEn  = irqEn_q;
endmodule : iic_core

// >>> pkg/iic_pkg.sv
// Purpose: Shared constants for the isolated input change-of-state board logic.
// Assumes: Byte-wide I/O cycles on a PC/104 style bus, 10-bit I/O address.
// Notes:   Offsets are register selects within the eight-address block.
package iic_pkg;
  localparam int         ChannelCount     = 16;
  localparam int         AddrWidth        = 10;
  localparam int         BaseLsb          = 3;
  localparam logic [2:0] OffInputLow      = 3'h0;
  localparam logic [2:0] OffClear         = 3'h1;
  localparam logic [2:0] OffEnable        = 3'h2;
  localparam logic [2:0] OffInputHigh     = 3'h4;
  localparam logic       EnableReset      = 1'b0;
  localparam logic       PendingReset     = 1'b0;
  localparam logic [6:0] BaseDefault      = 7'h40;
  localparam int         IrqLineCount     = 16;
endpackage : iic_pkg

// >>> logic/iic_sync.sv
// Purpose: Two-flop synchroniser for a group of asynchronous input levels.
// Assumes: Inputs are slow levels; each bit is synchronised independently.
// Notes:   The first stage is read only by the second stage.
module iic_sync #(
  parameter int Width = 16
) (
  // Clock and reset
  input  wire logic             sys_clk,
  input  wire logic             reset_n,
  // Levels
  input  wire logic [Width-1:0] asyncIn,
  output logic      [Width-1:0] syncOut
);
  logic [Width-1:0] stage1_q;

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      stage1_q <= '0;
      syncOut  <= '0;
    end else begin
      stage1_q <= asyncIn;
      syncOut  <= stage1_q;
    end
  end
endmodule : iic_sync

// >>> testbench/iic_checker.sv
// Purpose: Core port checks. Assumes: Host model timing. Notes: Windows allow sync delay.
module iic_checker (
  input wire logic sys_clk, reset_n, ioRead_n, ioWrite_n, addrEnable, dataOutEn,
  input wire logic [6:0] baseJumper, input wire logic [3:0] irqSelect,
  input wire logic [9:0] hostAddr, input wire logic [15:0] irqOut, irqOutEn, fieldIn
);
  timeunit 1ns / 1ns;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  wire logic hit = hostAddr[9:3] == baseJumper && !addrEnable;
  sequence rdHit; $fell(ioRead_n) && hit; endsequence
  a_read_drive: assert property (rdHit |-> ##[1:4] dataOutEn) else $error("read");
  a_drive_drop: assert property ($rose(ioRead_n) |-> ##[1:4] !dataOutEn)
    else $error("drop");
  a_foreign_quiet: assert property ($fell(ioRead_n) && !hit |-> ##3 !dataOutEn [*3])
    else $error("foreign");
  a_write_quiet: assert property ($fell(ioWrite_n) |-> ##1 !dataOutEn [*4])
    else $error("write");
  a_one_line: assert property ($past(reset_n) |-> irqOutEn == 16'h1 << irqSelect)
    else $error("line");
  a_irq_line: assert property ((irqOut & ~irqOutEn) == 16'h0) else $error("off line");
  a_irq_cause: assert property ($rose(|irqOut) |-> $past(fieldIn,2) != $past(fieldIn,6))
    else $error("cause");
  a_clear_cause: assert property ($fell(|irqOut) |-> !$past(ioWrite_n,2))
    else $error("clear");
endmodule : iic_checker
bind iic_core iic_checker i_iic_checker (.*);

// >>> testbench/iic_host.sv
// Purpose: Host bus model. Assumes: Calls follow an edge. Notes: Idle address is inverted.
module iic_host (
  input  wire logic sys_clk, dataOutEn,
  input  wire logic [7:0] dataOut,
  output logic [9:0] hostAddr = 10'h0,
  output logic ioRead_n = 1'b1, ioWrite_n = 1'b1, addrEnable = 1'b1
);
  timeunit 1ns / 1ns;
  logic [8:0] rdResp;
  task automatic xfer(logic rd, logic [10:0] a);
    @(posedge sys_clk);
    {addrEnable, hostAddr} <= a;
    {ioRead_n, ioWrite_n} <= {!rd, rd};
    repeat (5) @(posedge sys_clk);
    rdResp = {dataOutEn, dataOut};
    {ioRead_n, ioWrite_n} <= 2'h3;
    hostAddr <= ~a[9:0];
    repeat (4) @(posedge sys_clk);
  endtask : xfer
endmodule : iic_host

// >>> testbench/iic_core_tb.sv
// Purpose: Core test. Assumes: Base 0x200, line five. Notes: Waits cover sync delay.
module iic_core_tb;
  timeunit 1ns / 1ns;
  logic sys_clk = 1'b0, reset_n = 1'b0, ioRead_n, ioWrite_n, addrEnable, dataOutEn;
  logic [15:0] fieldIn = 16'h0, irqOut, irqOutEn;
  logic [9:0] hostAddr;
  logic [7:0] dataOut;
  int nMismatch = 0, checked = 0, cycles = 0;
  iic_core i_iic_core (.*, .baseJumper(7'h40), .irqSelect(4'h5));
  iic_host i_iic_host (.*);
  initial forever #50 sys_clk = ~sys_clk;
  always @(posedge sys_clk) if (++cycles == 2000) printVerdict(1);
  task automatic check(string w, logic [15:0] seen, exp);
    checked++;
    nMismatch += int'(seen !== exp);
    if (seen !== exp) $display("CHECK FAILED %s expected %h seen %h", w, exp, seen);
  endtask : check
  task automatic printVerdict(int extra);
    nMismatch += extra;
    $display("mismatch %0d check %0d", nMismatch, checked);
    if (nMismatch == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : printVerdict
  task automatic chg(logic [15:0] f, e);
    fieldIn <= f;
    repeat (8) @(posedge sys_clk);
    check("irq", irqOut, e);
  endtask : chg
  initial begin
    repeat (4) @(posedge sys_clk);
    reset_n <= 1'b1;
    // The base 0x200 lies inside the allowed range and overlaps nothing here.
    i_iic_host.xfer(1'b0, 11'h201);
    i_iic_host.xfer(1'b1, 11'h202);
    chg(16'h0001, 16'h0020);
    i_iic_host.xfer(1'b0, 11'h202);
    check("irq", irqOut, 16'h0020);
    i_iic_host.xfer(1'b0, 11'h201);
    chg(16'h8001, 16'h0000);
    i_iic_host.xfer(1'b1, 11'h202);
    chg(16'ha5c2, 16'h0020);
    // Reads past the block flip one address bit each, then the enable line.
    for (int i = 0; i < 16; i++) begin
      i_iic_host.xfer(1'b1, i < 8 ? 11'h200 + 11'(i) : 11'h200 ^ (11'h1 << (i - 5)));
      check("read", 16'(i < 8 ? i_iic_host.rdResp : i_iic_host.rdResp & 9'h100),
        i == 0 ? 16'h1c2 : i == 4 ? 16'h1a5 : i < 8 ? 16'h100 : 16'h0);
    end
    printVerdict(0);
  end
endmodule : iic_core_tb
